//--- period_timer.sv
// period timer with prescaler, postscaler, interrupt and Avalon-MM slave
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module period_timer #(
  parameter int COUNT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  output logic periodMatchPulse
);
  logic [COUNT_W-1:0] timerCount;
  logic [COUNT_W-1:0] periodValue;
  logic [6:0] timerControl;
  logic sleepMode;
  logic [1:0] instrDiv;
  logic [5:0] preCount;
  logic [3:0] postCount;
  logic irqStatus;
  logic irqEnable;
  logic accessDone;
  logic [5:0] preLimit;
  logic instrTick;
  logic scaledTick;
  logic running;
  logic isMatch;
  logic [2:0] wordIdx;
  logic wrStrobe;
  logic rdStrobe;
  logic wrCount;
  logic wrPeriod;
  logic wrControl;
  logic wrLane0;
  logic postDone;
  logic scalerClear;

  // bus decode: one wait cycle, then the access completes
  assign wordIdx = address[4:2];
  assign wrLane0 = byteenable[0];
  assign wrStrobe = write && accessDone;
  assign rdStrobe = read && accessDone;
  assign wrCount = wrStrobe && wrLane0 && (wordIdx == period_timer_pkg::TIMER_COUNT_IDX);
  assign wrPeriod = wrStrobe && wrLane0 && (wordIdx == period_timer_pkg::PERIOD_VALUE_IDX);
  assign wrControl = wrStrobe && wrLane0 && (wordIdx == period_timer_pkg::TIMER_CONTROL_IDX);

  // timer gating and tick generation
  assign running = timerControl[period_timer_pkg::TIMER_ON_POS] && !sleepMode;
  assign scalerClear = wrCount || wrControl; // count or control write cycle never ticks
  assign instrTick = running && !scalerClear
                     && (instrDiv == 2'(period_timer_pkg::INSTR_DIV - 1));
  always_comb begin
    case (timerControl[period_timer_pkg::PRESCALE_LSB +: 2])
      2'h0: preLimit = period_timer_pkg::PRE_DIV1;
      2'h1: preLimit = period_timer_pkg::PRE_DIV4;
      2'h2: preLimit = period_timer_pkg::PRE_DIV16;
      default: preLimit = period_timer_pkg::PRE_DIV64;
    endcase
  end
  assign scaledTick = instrTick && (preCount >= preLimit);
  assign isMatch = scaledTick && (timerCount == periodValue);
  assign postDone = isMatch && (postCount == timerControl[period_timer_pkg::POSTSCALE_LSB +: 4]);

  // bus handshake: waitrequest drops for one cycle per access
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      accessDone <= 1'b0;
    end else begin
      accessDone <= (read || write) && !accessDone;
    end
  end

  // waitrequest registered, low in the completing cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && !accessDone);
    end
  end

  // instruction clock divider, free running while timer runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instrDiv <= 2'h0;
    end else if (wrCount || wrControl) begin
      instrDiv <= 2'h0;
    end else if (running) begin
      instrDiv <= instrDiv + 2'h1;
    end
  end

  // prescaler counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preCount <= 6'h00;
    end else if (wrCount || wrControl) begin
      preCount <= 6'h00;
    end else if (scaledTick) begin
      preCount <= 6'h00;
    end else if (instrTick) begin
      preCount <= preCount + 6'h01;
    end
  end

  // count register: software write, reload on match, step on tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerCount <= period_timer_pkg::COUNT_RESET;
    end else if (wrCount) begin
      timerCount <= writedata[COUNT_W-1:0];
    end else if (isMatch) begin
      timerCount <= period_timer_pkg::COUNT_RESET;
    end else if (scaledTick) begin
      timerCount <= timerCount + COUNT_W'(1);
    end
  end

  // period register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periodValue <= period_timer_pkg::PERIOD_RESET;
    end else if (wrPeriod) begin
      periodValue <= writedata[COUNT_W-1:0];
    end
  end

  // control register, bit 7 not stored; count untouched here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerControl <= period_timer_pkg::CONTROL_RESET;
    end else if (wrControl) begin
      timerControl <= writedata[6:0];
    end
  end

  // sleep control, stands in for processor sleep state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleepMode <= 1'b0;
    end else if (wrStrobe && wrLane0 && (wordIdx == period_timer_pkg::SLEEP_CTRL_IDX)) begin
      sleepMode <= writedata[0];
    end
  end

  // postscaler counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      postCount <= 4'h0;
    end else if (wrCount || wrControl) begin
      postCount <= 4'h0;
    end else if (postDone) begin
      postCount <= 4'h0;
    end else if (isMatch) begin
      postCount <= postCount + 4'h1;
    end
  end

  // match pulse straight from a flop, one system clock wide
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periodMatchPulse <= 1'b0;
    end else begin
      periodMatchPulse <= isMatch;
    end
  end

  // sticky match flag, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatus <= 1'b0;
    end else if (postDone) begin
      irqStatus <= 1'b1;
    end else if (wrStrobe && wrLane0 && (wordIdx == period_timer_pkg::IRQ_CLEAR_IDX)
                 && writedata[period_timer_pkg::MATCH_IRQ_POS]) begin
      irqStatus <= 1'b0;
    end
  end

  // interrupt enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqEnable <= 1'b0;
    end else if (wrStrobe && wrLane0 && (wordIdx == period_timer_pkg::IRQ_ENABLE_IDX)) begin
      irqEnable <= writedata[period_timer_pkg::MATCH_IRQ_POS];
    end
  end

  // interrupt output, registered from current status and enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irqEnable && irqStatus;
    end
  end

  // read data mux, unmapped and write-only read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !accessDone) begin
      case (wordIdx)
        period_timer_pkg::TIMER_COUNT_IDX: readdata <= {24'h00_0000, timerCount};
        period_timer_pkg::PERIOD_VALUE_IDX: readdata <= {24'h00_0000, periodValue};
        period_timer_pkg::TIMER_CONTROL_IDX: readdata <= {25'h000_0000, timerControl};
        period_timer_pkg::IRQ_STATUS_IDX: readdata <= {31'h0000_0000, irqStatus};
        period_timer_pkg::IRQ_ENABLE_IDX: readdata <= {31'h0000_0000, irqEnable};
        period_timer_pkg::SLEEP_CTRL_IDX: readdata <= {31'h0000_0000, sleepMode};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // match only when count equals period on a tick
  a_match_cause: assert property (@(posedge clk) disable iff (rst)
    isMatch |-> (timerCount == periodValue) && running)
    else $error("match without equal count");

  // reload to zero after match
  a_match_reload: assert property (@(posedge clk) disable iff (rst)
    isMatch && !wrCount |=> timerCount == 8'h00)
    else $error("count not reloaded after match");

  // match pulse follows match one cycle later
  a_pulse_timing: assert property (@(posedge clk) disable iff (rst)
    isMatch |=> periodMatchPulse)
    else $error("match pulse missing");

  // off timer holds count
  a_off_hold: assert property (@(posedge clk) disable iff (rst)
    !running && !wrCount |=> $stable(timerCount))
    else $error("count moved while stopped");

  // control write clears scalers and keeps count
  a_ctrl_write: assert property (@(posedge clk) disable iff (rst)
    wrControl |=> postCount == 4'h0 && preCount == 6'h00 && $stable(timerCount))
    else $error("control write effect wrong");

  // count steps by exactly one on a plain tick
  a_count_step: assert property (@(posedge clk) disable iff (rst)
    scaledTick && !isMatch && !wrCount |=> timerCount == $past(timerCount) + 8'h01)
    else $error("count did not step by one");

  // flag sticks until cleared
  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    irqStatus && !(wrStrobe && wordIdx == period_timer_pkg::IRQ_CLEAR_IDX) |=> irqStatus)
    else $error("flag dropped on its own");

  // interrupt gated by enable
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    irq |-> $past(irqEnable) && $past(irqStatus))
    else $error("irq without enable");

  // prescale 1:1 ticks every instruction tick
  a_prescale_one: assert property (@(posedge clk) disable iff (rst)
    instrTick && timerControl[1:0] == 2'h0 |-> scaledTick)
    else $error("divide by one missed tick");

  // ticks at most once every four clocks
  a_instr_rate: assert property (@(posedge clk) disable iff (rst)
    instrTick |=> (!instrTick) [*3])
    else $error("instruction tick too fast");

  // count write clears divider, prescaler and postscaler
  a_count_clear: assert property (@(posedge clk) disable iff (rst)
    wrCount |=> instrDiv == 2'h0 && preCount == 6'h00 && postCount == 4'h0)
    else $error("count write left a scaler running");

  // count write lands as written
  a_count_write: assert property (@(posedge clk) disable iff (rst)
    wrCount |=> timerCount == $past(writedata[COUNT_W-1:0]))
    else $error("count write lost");

  // period write lands as written
  a_period_write: assert property (@(posedge clk) disable iff (rst)
    wrPeriod |=> periodValue == $past(writedata[COUNT_W-1:0]))
    else $error("period write lost");

  // period only moves on its own write, sleep included
  a_period_hold: assert property (@(posedge clk) disable iff (rst)
    !wrPeriod |=> $stable(periodValue))
    else $error("period moved without a write");

  // sleeping timer keeps its count
  a_sleep_hold: assert property (@(posedge clk) disable iff (rst)
    sleepMode && !wrCount |=> $stable(timerCount))
    else $error("count moved during sleep");

  // count read returns the count of the request cycle
  a_read_count: assert property (@(posedge clk) disable iff (rst)
    read && !accessDone && wordIdx == period_timer_pkg::TIMER_COUNT_IDX
    |=> readdata[COUNT_W-1:0] == $past(timerCount))
    else $error("count read wrong");

  // control read shows bit 7 and above as zero
  a_ctrl_bit7: assert property (@(posedge clk) disable iff (rst)
    read && !accessDone && wordIdx == period_timer_pkg::TIMER_CONTROL_IDX
    |=> readdata[31:7] == 25'h000_0000)
    else $error("control bit 7 not zero");

  // request answered after one wait cycle
  a_wait_answer: assert property (@(posedge clk) disable iff (rst)
    (read || write) && !accessDone |=> !waitrequest)
    else $error("access not answered");

  // waitrequest never low two cycles running
  a_wait_pulse: assert property (@(posedge clk) disable iff (rst)
    !waitrequest |=> waitrequest)
    else $error("waitrequest low too long");

  // strobes only in the completing cycle
  a_strobe_done: assert property (@(posedge clk) disable iff (rst)
    (rdStrobe || wrStrobe) |-> !waitrequest)
    else $error("strobe outside completing cycle");

  // postscaler never passes its selected count
  a_post_bound: assert property (@(posedge clk) disable iff (rst)
    postCount <= timerControl[period_timer_pkg::POSTSCALE_LSB +: 4])
    else $error("postscaler beyond its limit");

  // each match short of the limit advances the postscaler
  a_post_step: assert property (@(posedge clk) disable iff (rst)
    isMatch && !postDone |=> postCount == $past(postCount) + 4'h1)
    else $error("postscaler did not advance");

  // completed postscale count latches the flag
  a_flag_set: assert property (@(posedge clk) disable iff (rst)
    postDone |=> irqStatus)
    else $error("flag not latched");

  // flag rises only on a completed postscale count
  a_flag_cause: assert property (@(posedge clk) disable iff (rst)
    $rose(irqStatus) |-> $past(postDone))
    else $error("flag set without cause");

  // stopped timer makes no match and no flag
  a_off_quiet: assert property (@(posedge clk) disable iff (rst)
    !running |-> !isMatch && !postDone)
    else $error("match while stopped");

  // match pulse one clock wide
  a_pulse_width: assert property (@(posedge clk) disable iff (rst)
    periodMatchPulse |=> !periodMatchPulse)
    else $error("match pulse too wide");

  // match pulse only after a match
  a_pulse_cause: assert property (@(posedge clk) disable iff (rst)
    periodMatchPulse |-> $past(isMatch))
    else $error("match pulse without match");

  // enabled set flag raises the interrupt
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    irqStatus && irqEnable |=> irq)
    else $error("enabled flag gave no irq");

endmodule : period_timer
`default_nettype wire

//--- period_timer_pkg.sv
// package: register map, fields and reset values of the period timer
package period_timer_pkg;
  // register word offsets (byte addresses / 4)
  localparam logic [2:0] TIMER_COUNT_IDX = 3'h0;
  localparam logic [2:0] PERIOD_VALUE_IDX = 3'h1;
  localparam logic [2:0] TIMER_CONTROL_IDX = 3'h2;
  localparam logic [2:0] IRQ_STATUS_IDX = 3'h3;
  localparam logic [2:0] IRQ_ENABLE_IDX = 3'h4;
  localparam logic [2:0] IRQ_CLEAR_IDX = 3'h5;
  localparam logic [2:0] SLEEP_CTRL_IDX = 3'h6;
  // control field positions
  localparam int PRESCALE_LSB = 0;
  localparam int TIMER_ON_POS = 2;
  localparam int POSTSCALE_LSB = 3;
  // interrupt bit position
  localparam int MATCH_IRQ_POS = 0;
  // reset values
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [6:0] CONTROL_RESET = 7'h00;
  // instruction clock divider (system clock / 4)
  localparam int INSTR_DIV = 4;
  // prescale ratios
  localparam logic [5:0] PRE_DIV1 = 6'h00;
  localparam logic [5:0] PRE_DIV4 = 6'h03;
  localparam logic [5:0] PRE_DIV16 = 6'h0f;
  localparam logic [5:0] PRE_DIV64 = 6'h3f;
endpackage : period_timer_pkg

//--- tb.sv
// self-checking testbench of the period timer over its Avalon-MM registers
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic periodMatchPulse;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int lastPulse = 0;
  int interval = 0;
  int pulseCount = 0;
  int n;
  int saved;
  integer rndSeed = 25078;
  logic [31:0] rd;
  logic [31:0] rnd;
  logic [7:0] per;
  logic [3:0] post;

  period_timer dut (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .periodMatchPulse(periodMatchPulse)
  );

  // clock
  always #5 clk = ~clk;

  // cycle count, timeout and match pulse monitor
  always @(posedge clk) begin
    cycles++;
    if (periodMatchPulse === 1'b1) begin
      pulseCount++;
      interval = cycles - lastPulse;
      lastPulse = cycles;
    end
    if (cycles == 60000) begin
      num_errors++;
      complete_run();
    end
  end

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic [2:0] idx, input logic wr, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= ~wr;
    write <= wr;
    writedata <= {24'h00_0000, d};
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(idx, 1'b1, d, 4'hf, q);
  endtask : wr

  task automatic rdc(input logic [2:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(idx, 1'b0, 8'h00, 4'hf, q);
    check(q, {24'h00_0000, exp});
  endtask : rdc

  task automatic waitPulses(input int cnt);
    int start;
    @(negedge clk);
    start = pulseCount;
    while (pulseCount < start + cnt) @(negedge clk);
  endtask : waitPulses

  // clocks between matches: period plus one ticks of divided clock
  function automatic int expInterval(input logic [7:0] p, input int ps);
    return (p + 1) * period_timer_pkg::INSTR_DIV * (1 << (2 * ps));
  endfunction : expInterval

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(period_timer_pkg::TIMER_COUNT_IDX, 8'h00);
    rdc(period_timer_pkg::PERIOD_VALUE_IDX, 8'hff);
    rdc(period_timer_pkg::TIMER_CONTROL_IDX, 8'h00);
    rdc(3'h7, 8'h00);
    // random values, refused byte lane, control write keeps count
    repeat (4) begin
      rnd = $random(rndSeed);
      per = rnd[15:8];
      wr(period_timer_pkg::TIMER_COUNT_IDX, rnd[7:0]);
      wr(period_timer_pkg::PERIOD_VALUE_IDX, per);
      bus(period_timer_pkg::PERIOD_VALUE_IDX, 1'b1, ~per, 4'he, rd);
      rdc(period_timer_pkg::TIMER_COUNT_IDX, rnd[7:0]);
      rdc(period_timer_pkg::PERIOD_VALUE_IDX, per);
      wr(period_timer_pkg::TIMER_CONTROL_IDX, {1'b1, rnd[19:16], 1'b0, rnd[21:20]});
      rdc(period_timer_pkg::TIMER_CONTROL_IDX, {1'b0, rnd[19:16], 1'b0, rnd[21:20]});
      rdc(period_timer_pkg::TIMER_COUNT_IDX, rnd[7:0]);
    end
    // match interval for every prescale code
    for (int ps = 0; ps < 4; ps++) begin
      rnd = $random(rndSeed);
      per = 8'h01 + {6'h00, rnd[1:0]};
      wr(period_timer_pkg::TIMER_CONTROL_IDX, 8'h00);
      wr(period_timer_pkg::TIMER_COUNT_IDX, 8'h00);
      wr(period_timer_pkg::PERIOD_VALUE_IDX, per);
      wr(period_timer_pkg::TIMER_CONTROL_IDX, 8'h04 | {6'h00, ps[1:0]});
      waitPulses(3);
      check(interval, expInterval(per, ps));
    end
    // postscale ratio, masking, sticky flag, stopped timer
    for (int k = 0; k < 3; k++) begin
      rnd = $random(rndSeed);
      post = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : rnd[3:0];
      wr(period_timer_pkg::TIMER_CONTROL_IDX, 8'h00);
      wr(period_timer_pkg::TIMER_COUNT_IDX, 8'h00);
      wr(period_timer_pkg::PERIOD_VALUE_IDX, 8'h02);
      wr(period_timer_pkg::IRQ_CLEAR_IDX, 8'h01);
      wr(period_timer_pkg::IRQ_ENABLE_IDX, 8'h01);
      wr(period_timer_pkg::TIMER_CONTROL_IDX, {1'b0, post, 3'b100});
      @(negedge clk);
      saved = pulseCount;
      n = 0;
      while (irq !== 1'b1 && n < 600) begin
        @(negedge clk);
        n++;
      end
      check(pulseCount - saved, post + 1);
      wr(period_timer_pkg::TIMER_CONTROL_IDX, 8'h00);
      bus(period_timer_pkg::TIMER_COUNT_IDX, 1'b0, 8'h00, 4'hf, rd);
      saved = pulseCount;
      repeat (40) @(posedge clk);
      rdc(period_timer_pkg::TIMER_COUNT_IDX, rd[7:0]);
      check(pulseCount, saved);
      wr(period_timer_pkg::IRQ_ENABLE_IDX, 8'h00);
      repeat (2) @(negedge clk);
      check(irq, 1'b0);
      rdc(period_timer_pkg::IRQ_STATUS_IDX, 8'h01);
      wr(period_timer_pkg::IRQ_CLEAR_IDX, 8'h01);
      rdc(period_timer_pkg::IRQ_STATUS_IDX, 8'h00);
    end
    // sleep freezes count and period, waking resumes counting
    wr(period_timer_pkg::PERIOD_VALUE_IDX, 8'h80);
    wr(period_timer_pkg::TIMER_CONTROL_IDX, 8'h04);
    wr(period_timer_pkg::SLEEP_CTRL_IDX, 8'h01);
    bus(period_timer_pkg::TIMER_COUNT_IDX, 1'b0, 8'h00, 4'hf, rd);
    repeat (40) @(posedge clk);
    rdc(period_timer_pkg::TIMER_COUNT_IDX, rd[7:0]);
    rdc(period_timer_pkg::PERIOD_VALUE_IDX, 8'h80);
    wr(period_timer_pkg::SLEEP_CTRL_IDX, 8'h00);
    repeat (40) @(posedge clk);
    bus(period_timer_pkg::TIMER_COUNT_IDX, 1'b0, 8'h00, 4'hf, rnd);
    check(rnd[7:0] != rd[7:0], 1'b1);
    // reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(period_timer_pkg::TIMER_COUNT_IDX, 8'h00);
    rdc(period_timer_pkg::PERIOD_VALUE_IDX, 8'hff);
    complete_run();
  end
endmodule : tb
`default_nettype wire
